// ===== rtl/adc_control_readout.sv
// Register file, sequencing and readout of the monitoring converter
`timescale 1ns/1ns

module adc_control_readout #(
	// Revision value is arbitrary
	parameter logic [2:0] SILICON_REV = 3'h1
)(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic [7:0]  reg_wr_data,
	input  wire logic        reg_rd_en,
	output logic      [7:0]  reg_rd_data,
	input  wire logic        conv_done,
	input  wire logic [13:0] conv_result,
	output logic             conv_start,
	output logic      [2:0]  conv_channel,
	output logic             conv_enable,
	output logic             front_amp_off,
	output logic             input_flip
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic        enable_q, enable_d;
	logic        single_q, single_d;
	logic        sweep_q, sweep_d;
	logic        amp_off_q, amp_off_d;
	logic        flip_q, flip_d;
	logic [2:0]  rdsel_q, rdsel_d;
	logic [2:0]  cvsel_q, cvsel_d;
	logic        ready_q, ready_d;
	logic [7:0]  rd_data_q, rd_data_d;

	logic        cfg_one_wr;
	logic        cfg_two_wr;
	logic        store_en;
	logic        run_start;
	logic        seq_enable;
	logic [13:0] sel_result;
	logic [7:0]  sel_high;
	logic [5:0]  sel_low;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	assign cfg_one_wr = reg_wr_en && reg_addr == adc_ctl_pkg::CFG_ONE_OFS;
	assign cfg_two_wr = reg_wr_en && reg_addr == adc_ctl_pkg::CFG_TWO_OFS;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_comb begin
		enable_d  = enable_q;
		single_d  = single_q;
		sweep_d   = sweep_q;
		amp_off_d = amp_off_q;
		flip_d    = flip_q;
		rdsel_d   = rdsel_q;
		cvsel_d   = cvsel_q;
		if (cfg_one_wr) begin
			enable_d  = reg_wr_data[adc_ctl_pkg::ENABLE_BIT];
			single_d  = reg_wr_data[adc_ctl_pkg::SINGLE_BIT];
			sweep_d   = reg_wr_data[adc_ctl_pkg::SWEEP_BIT];
			amp_off_d = reg_wr_data[adc_ctl_pkg::AMP_OFF_BIT];
			flip_d    = reg_wr_data[adc_ctl_pkg::FLIP_BIT];
		end
		if (cfg_two_wr) begin
			rdsel_d = reg_wr_data[adc_ctl_pkg::RDSEL_LSB +: 3];
			cvsel_d = reg_wr_data[adc_ctl_pkg::CVSEL_LSB +: 3];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable_q  <= adc_ctl_pkg::CTRL_RESET;
			single_q  <= adc_ctl_pkg::CTRL_RESET;
			sweep_q   <= adc_ctl_pkg::CTRL_RESET;
			amp_off_q <= adc_ctl_pkg::CTRL_RESET;
			flip_q    <= adc_ctl_pkg::CTRL_RESET;
			rdsel_q   <= adc_ctl_pkg::SELECT_RESET;
			cvsel_q   <= adc_ctl_pkg::SELECT_RESET;
		end else begin
			enable_q  <= enable_d;
			single_q  <= single_d;
			sweep_q   <= sweep_d;
			amp_off_q <= amp_off_d;
			flip_q    <= flip_d;
			rdsel_q   <= rdsel_d;
			cvsel_q   <= cvsel_d;
		end
	end

	assign conv_enable   = enable_q;
	assign front_amp_off = amp_off_q;
	assign input_flip    = flip_q;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Drops out at the disabling write so no start follows while disabled
	assign seq_enable = enable_q && enable_d;

	conv_sequencer u_seq (
		.core_clk       (core_clk),
		.rst            (rst),
		.enable         (seq_enable),
		.single_pass    (single_q),
		.sweep_all      (sweep_q),
		.rearm          (cfg_one_wr),
		.convert_select (cvsel_q),
		.conv_done      (conv_done),
		.conv_start     (conv_start),
		.conv_channel   (conv_channel),
		.store_en       (store_en),
		.run_start      (run_start)
	);

	// ------------------------------------------------------------
	// Result storage
	// ------------------------------------------------------------
	// channel code indexes the store
	result_store #(
		.CHANNELS (8),
		.WIDTH    (14)
	) u_store (
		.core_clk      (core_clk),
		.rst           (rst),
		.store_en      (store_en),
		.store_channel (conv_channel),
		.store_data    (conv_result),
		.read_channel  (rdsel_q),
		.read_data     (sel_result)
	);

	assign sel_high = sel_result[13:adc_ctl_pkg::RESULT_SPLIT];
	assign sel_low  = sel_result[adc_ctl_pkg::RESULT_SPLIT-1:0];

	// ------------------------------------------------------------
	// Data ready flag
	// ------------------------------------------------------------
	always_comb begin
		ready_d = ready_q;
		// clear on fresh run or disable
		if (run_start || !enable_q) begin
			ready_d = 1'b0;
		end
		if (store_en) begin
			ready_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ready_q <= adc_ctl_pkg::CTRL_RESET;
		end else begin
			ready_q <= ready_d;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		rd_data_d = rd_data_q;
		if (reg_rd_en) begin
			case (reg_addr)
				adc_ctl_pkg::RESULT_HIGH_OFS: begin
					rd_data_d = sel_high;
				end
				adc_ctl_pkg::RESULT_LOW_OFS: begin
					rd_data_d = {2'b00, sel_low};
				end
				adc_ctl_pkg::CFG_ONE_OFS: begin
					rd_data_d = {enable_q, single_q, sweep_q, amp_off_q, flip_q,
					             SILICON_REV};
				end
				adc_ctl_pkg::CFG_TWO_OFS: begin
					rd_data_d = {ready_q, 1'b0, rdsel_q, cvsel_q};
				end
				default: begin
					rd_data_d = adc_ctl_pkg::RDATA_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= adc_ctl_pkg::RDATA_RESET;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign reg_rd_data = rd_data_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic rd_high;
	logic rd_low;
	logic rd_one;
	logic rd_two;
	assign rd_high = reg_rd_en && reg_addr == adc_ctl_pkg::RESULT_HIGH_OFS;
	assign rd_low  = reg_rd_en && reg_addr == adc_ctl_pkg::RESULT_LOW_OFS;
	assign rd_one  = reg_rd_en && reg_addr == adc_ctl_pkg::CFG_ONE_OFS;
	assign rd_two  = reg_rd_en && reg_addr == adc_ctl_pkg::CFG_TWO_OFS;

	chk_high_byte: assert property (
		rd_high |=> reg_rd_data == $past(sel_high))
		else $error("high result byte does not match stored bits");

	chk_low_byte: assert property (
		rd_low |=> reg_rd_data[5:0] == $past(sel_low))
		else $error("low result byte does not match stored bits");

	chk_low_spare_zero: assert property (
		rd_low |=> reg_rd_data[7:6] == 2'b00)
		else $error("spare bits of low result byte not zero");

	chk_readout_route: assert property (
		store_en && conv_channel == rdsel_q && !cfg_two_wr ##1 rd_high
		|=> reg_rd_data == $past(conv_result[13:6], 2))
		else $error("stored result not routed to readout");

	chk_enable_gates: assert property (
		!enable_q |-> !conv_start && !store_en)
		else $error("conversion activity while disabled");

	chk_flip_follows: assert property (
		cfg_one_wr |=> input_flip == $past(reg_wr_data[3]))
		else $error("input flip does not follow its control bit");

	chk_ready_set: assert property (
		store_en |=> (ready_q and (rd_two |=> reg_rd_data[adc_ctl_pkg::READY_BIT])))
		else $error("ready flag not set after a store");

	chk_select_readback: assert property (
		cfg_two_wr ##1 rd_two
		|=> reg_rd_data[5:0] == $past(reg_wr_data[5:0], 2))
		else $error("channel selects do not read back");

	chk_rev_field: assert property (
		rd_one |=> reg_rd_data[2:0] == SILICON_REV)
		else $error("revision field wrong");

	chk_ready_clear: assert property (
		(!enable_q || run_start) && !store_en |=> !ready_q)
		else $error("ready flag not cleared");

	cov_read_high: cover property (ready_q && rd_high);

	cov_flip_on: cover property (input_flip && store_en);

endmodule

// ===== rtl/adc_ctl_pkg.sv
// Shared constants for the converter control and readout block
package adc_ctl_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] RESULT_HIGH_OFS = 8'h07;
	localparam logic [7:0] RESULT_LOW_OFS  = 8'h08;
	localparam logic [7:0] CFG_ONE_OFS     = 8'h09;
	localparam logic [7:0] CFG_TWO_OFS     = 8'h0A;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ENABLE_BIT     = 7;
	localparam int SINGLE_BIT     = 6;
	localparam int SWEEP_BIT      = 5;
	localparam int AMP_OFF_BIT    = 4;
	localparam int FLIP_BIT       = 3;
	localparam int READY_BIT      = 7;
	localparam int RDSEL_LSB      = 3;
	localparam int CVSEL_LSB      = 0;
	localparam int RESULT_SPLIT   = 6;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic       CTRL_RESET   = 1'b0;
	localparam logic [2:0] SELECT_RESET = 3'h0;
	localparam logic [7:0] RDATA_RESET  = 8'h00;
	localparam logic [13:0] RESULT_RESET = 14'h0000;

	// ------------------------------------------------------------
	// Channel codes
	// ------------------------------------------------------------
	localparam logic [2:0] CH_CURRENT_LIMIT_PIN = 3'h0;
	localparam logic [2:0] CH_INPUT_VOLTAGE     = 3'h1;
	localparam logic [2:0] CH_BATTERY_VOLTAGE   = 3'h2;
	localparam logic [2:0] CH_OUTPUT_LIMIT_PIN  = 3'h3;
	localparam logic [2:0] CH_THERMISTOR_INPUT  = 3'h4;
	localparam logic [2:0] CH_DIE_TEMPERATURE   = 3'h5;
	localparam logic [2:0] CH_EXTERNAL_INPUT    = 3'h6;
	localparam logic [2:0] CH_ANALOG_GROUND     = 3'h7;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic {SEQ_IDLE, SEQ_WAIT} seq_state_e;

endpackage

// ===== rtl/conv_sequencer.sv
// Conversion sequencer for looped, swept and single-pass modes
`timescale 1ns/1ns
module conv_sequencer (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       enable,
	input  wire logic       single_pass,
	input  wire logic       sweep_all,
	input  wire logic       rearm,
	input  wire logic [2:0] convert_select,
	input  wire logic       conv_done,
	output logic            conv_start,
	output logic      [2:0] conv_channel,
	output logic            store_en,
	output logic            run_start
);

	adc_ctl_pkg::seq_state_e state_q, state_d;
	logic                    halted_q, halted_d;
	logic                    start_q, start_d;
	logic [2:0]              chan_q, chan_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d   = state_q;
		halted_d  = halted_q;
		start_d   = 1'b0;
		chan_d    = chan_q;
		store_en  = 1'b0;
		run_start = 1'b0;
		if (!enable) begin
			state_d  = adc_ctl_pkg::SEQ_IDLE;
			halted_d = 1'b0;
		end else begin
			case (state_q)
				adc_ctl_pkg::SEQ_IDLE: begin
					if (!halted_q || rearm) begin
						run_start = 1'b1;
						start_d   = 1'b1;
						halted_d  = 1'b0;
						state_d   = adc_ctl_pkg::SEQ_WAIT;
						chan_d    = sweep_all ? adc_ctl_pkg::CH_CURRENT_LIMIT_PIN
						                      : convert_select;
					end
				end
				adc_ctl_pkg::SEQ_WAIT: begin
					if (conv_done) begin
						store_en = 1'b1;
						if (single_pass && (!sweep_all ||
						    chan_q == adc_ctl_pkg::CH_ANALOG_GROUND)) begin
							halted_d = 1'b1;
							state_d  = adc_ctl_pkg::SEQ_IDLE;
						end else begin
							start_d = 1'b1;
							chan_d  = sweep_all ? 3'(chan_q + 3'h1) : convert_select;
						end
					end
				end
				default: begin
					state_d = adc_ctl_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q  <= adc_ctl_pkg::SEQ_IDLE;
			halted_q <= 1'b0;
			start_q  <= 1'b0;
			chan_q   <= adc_ctl_pkg::SELECT_RESET;
		end else begin
			state_q  <= state_d;
			halted_q <= halted_d;
			start_q  <= start_d;
			chan_q   <= chan_d;
		end
	end

	assign conv_start   = start_q;
	assign conv_channel = chan_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic wait_done;
	assign wait_done = enable && state_q == adc_ctl_pkg::SEQ_WAIT && conv_done;

	chk_loop_repeats: assert property (
		wait_done && !single_pass && !sweep_all
		|=> conv_start && conv_channel == $past(convert_select))
		else $error("looped mode did not restart the selected channel");

	chk_sweep_step: assert property (
		wait_done && !single_pass && sweep_all
		|=> conv_start && conv_channel == 3'($past(conv_channel) + 3'h1))
		else $error("sweep did not step to the next channel");

	chk_one_shot_halt: assert property (
		wait_done && single_pass && !sweep_all && !rearm
		|=> !conv_start ##1 (!conv_start || !$past(enable)))
		else $error("single pass did not stop");

	chk_sweep_once_end: assert property (
		wait_done && single_pass && sweep_all
		&& conv_channel == adc_ctl_pkg::CH_ANALOG_GROUND
		|=> !conv_start && halted_q)
		else $error("single sweep did not stop after the last channel");

	cov_sweep_wrap: cover property (
		wait_done && sweep_all && conv_channel == adc_ctl_pkg::CH_ANALOG_GROUND);

	cov_single_halt: cover property (wait_done && single_pass && !sweep_all);

endmodule

// ===== rtl/result_store.sv
// Per-channel store of the latest conversion results
`timescale 1ns/1ns
module result_store #(
	parameter int CHANNELS = 8,
	parameter int WIDTH    = 14
)(
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic                        store_en,
	input  wire logic [$clog2(CHANNELS)-1:0] store_channel,
	input  wire logic [WIDTH-1:0]            store_data,
	input  wire logic [$clog2(CHANNELS)-1:0] read_channel,
	output logic      [WIDTH-1:0]            read_data
);

	logic [WIDTH-1:0] mem_q [CHANNELS];
	logic [WIDTH-1:0] mem_d [CHANNELS];

	// ------------------------------------------------------------
	// Write side
	// ------------------------------------------------------------
	always_comb begin
		mem_d = mem_q;
		if (store_en) begin
			mem_d[store_channel] = store_data;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				mem_q[i] <= adc_ctl_pkg::RESULT_RESET;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	// ------------------------------------------------------------
	// Read side
	// ------------------------------------------------------------
	// readout by select
	assign read_data = mem_q[read_channel];

endmodule

// ===== sim/adc_far_model.sv
// Behavioural converter that answers start pulses after a chosen delay
`timescale 1ns/1ns
module adc_far_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        conv_start,
	input  wire logic [2:0]  conv_channel,
	input  wire logic        conv_enable,
	input  wire logic        front_amp_off,
	input  wire logic        input_flip,
	input  wire logic [3:0]  delay,
	input  wire logic [8:0]  salt,
	output logic             conv_done,
	output logic      [13:0] conv_result
);
	logic       busy_q;
	logic [3:0] cnt_q;
	logic [2:0] ch_q;

	// ------------------------------------------------------------
	// Conversion timing
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_q      <= 1'b0;
			cnt_q       <= 4'h0;
			ch_q        <= 3'h0;
			conv_done   <= 1'b0;
			conv_result <= 14'h2AAA;
		end else begin
			conv_done <= 1'b0;
			if (!conv_enable) begin
				busy_q      <= 1'b0;
				conv_result <= ~conv_result;
			end else if (conv_start) begin
				busy_q <= 1'b1;
				cnt_q  <= delay;
				ch_q   <= conv_channel;
			end else if (busy_q && cnt_q <= 4'h1) begin
				// result shows channel code and swap
				conv_done   <= 1'b1;
				conv_result <= {ch_q, input_flip, front_amp_off, salt};
				busy_q      <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end else begin
				conv_result <= ~conv_result;
			end
		end
	end
endmodule

// ===== sim/test_adc_control_readout.sv
// Self-checking bench for the converter control and readout block
`timescale 1ns/1ns
module test_adc_control_readout;
	localparam logic [2:0] REV = 3'h5;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr_en = 1'b0;
	logic [7:0]  reg_wr_data = 8'h00;
	logic        reg_rd_en = 1'b0;
	logic [7:0]  reg_rd_data;
	logic        conv_done;
	logic [13:0] conv_result;
	logic        conv_start;
	logic [2:0]  conv_channel;
	logic        conv_enable;
	logic        front_amp_off;
	logic        input_flip;
	logic [3:0]  delay = 4'h1;
	logic [8:0]  salt = 9'h000;
	logic [8:0]  salt_old;
	logic [7:0]  rd_q;
	logic [2:0]  cv;
	logic [13:0] r;
	logic [13:0] r0;
	logic [2:0]  chans[$];
	int          fail_count = 0;
	int          n_tests = 0;
	int          n_starts = 0;
	int          i;

	always #5 core_clk = ~core_clk;

	adc_control_readout #(.SILICON_REV(REV)) u_dut (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_enable(conv_enable),
		.front_amp_off(front_amp_off), .input_flip(input_flip)
	);

	adc_far_model u_far (
		.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_enable(conv_enable),
		.front_amp_off(front_amp_off), .input_flip(input_flip), .delay(delay),
		.salt(salt), .conv_done(conv_done), .conv_result(conv_result)
	);

	always @(posedge core_clk) begin
		if (conv_start === 1'b1) begin
			n_starts++;
			chans.push_back(conv_channel);
		end
	end

	function automatic logic [13:0] exp_res(logic [2:0] ch, logic flip, logic [8:0] s);
		return {ch, flip, 1'b0, s};
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		rd_q = reg_rd_data;
	endtask

	task automatic rd_res(input logic [2:0] ch, input logic [13:0] exp);
		wr(adc_ctl_pkg::CFG_TWO_OFS, {2'b00, ch, cv});
		rd(adc_ctl_pkg::RESULT_HIGH_OFS);
		r[13:6] = rd_q;
		check(rd_q, exp[13:6], "high byte");
		rd(adc_ctl_pkg::RESULT_LOW_OFS);
		r[5:0] = rd_q[5:0];
		check(rd_q, {2'b00, exp[5:0]}, "low byte");
	endtask

	task automatic wait_ready();
		for (int k = 0; k < 300; k++) begin
			rd(adc_ctl_pkg::CFG_TWO_OFS);
			if (rd_q[7] === 1'b1) break;
		end
	endtask

	task automatic new_run(input logic [7:0] cfg);
		wr(adc_ctl_pkg::CFG_ONE_OFS, 8'h00);
		delay = 4'($urandom_range(1, 8));
		n_starts = 0;
		chans.delete();
		wr(adc_ctl_pkg::CFG_TWO_OFS, {2'b00, cv, cv});
		wr(adc_ctl_pkg::CFG_ONE_OFS, cfg);
	endtask

	task automatic print_verdict();
		$display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#500000;
		fail_count++;
		$display("BAD t=%0t watchdog expired", $time);
		print_verdict();
	end

	initial begin
		void'($urandom(32'h87C7));
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		rd(adc_ctl_pkg::CFG_ONE_OFS);
		check(rd_q, {5'h00, REV}, "cfg one reset");
		rd(adc_ctl_pkg::CFG_TWO_OFS);
		check(rd_q, 8'h00, "cfg two reset");
		rd(adc_ctl_pkg::RESULT_HIGH_OFS);
		check(rd_q, 8'h00, "high reset");
		rd(8'h0B);
		check(rd_q, 8'h00, "unmapped read");
		wr(adc_ctl_pkg::RESULT_HIGH_OFS, 8'hFF);
		wr(adc_ctl_pkg::RESULT_LOW_OFS, 8'h3F);
		rd(adc_ctl_pkg::RESULT_LOW_OFS);
		check(rd_q, 8'h00, "low read only");
		wr(adc_ctl_pkg::CFG_ONE_OFS, 8'h0F);
		rd(adc_ctl_pkg::CFG_ONE_OFS);
		check(rd_q, {5'h01, REV}, "cfg one rw");
		check({5'h00, conv_enable, front_amp_off, input_flip}, 8'h01, "pins");
		wr(adc_ctl_pkg::CFG_ONE_OFS, 8'h00);
		check({7'h00, input_flip}, 8'h00, "flip cleared");
		wr(adc_ctl_pkg::CFG_TWO_OFS, 8'hBF);
		rd(adc_ctl_pkg::CFG_TWO_OFS);
		check(rd_q, 8'h3F, "cfg two rw");
		$display("test registers done");

		cv = 3'($urandom);
		salt = 9'($urandom);
		new_run(8'hC0);
		wait_ready();
		check({7'h00, rd_q[7]}, 8'h01, "ready set");
		rd_res(cv, exp_res(cv, 1'b0, salt));
		r0 = r;
		repeat (30) @(posedge core_clk);
		check(8'(n_starts), 8'h01, "single pass count");
		check({5'h00, chans[0]}, {5'h00, cv}, "single channel");
		wr(adc_ctl_pkg::CFG_ONE_OFS, 8'h00);
		rd(adc_ctl_pkg::CFG_TWO_OFS);
		check({7'h00, rd_q[7]}, 8'h00, "ready cleared");
		new_run(8'hC8);
		wait_ready();
		rd_res(cv, exp_res(cv, 1'b1, salt));
		check(8'((r + r0) >> 1), 8'((exp_res(cv, 1'b0, salt) + exp_res(cv, 1'b1, salt)) >> 1),
			"averaged reading");
		$display("test single done");

		salt = 9'($urandom);
		salt_old = salt;
		new_run(8'hE0);
		repeat (150) @(posedge core_clk);
		check(8'(n_starts), 8'h08, "one sweep count");
		for (i = 0; i < 8; i++) begin
			check({5'h00, chans[i]}, 8'(i), "sweep order");
			rd_res(3'(i), exp_res(3'(i), 1'b0, salt));
		end
		$display("test one sweep done");

		cv = 3'($urandom);
		salt = 9'($urandom);
		new_run(8'h80);
		repeat (80) @(posedge core_clk);
		check(8'(n_starts >= 3), 8'h01, "loop keeps running");
		foreach (chans[j]) check({5'h00, chans[j]}, {5'h00, cv}, "loop channel");
		rd_res(cv ^ 3'h5, exp_res(cv ^ 3'h5, 1'b0, salt_old));
		wr(adc_ctl_pkg::CFG_ONE_OFS, 8'h00);
		rd(adc_ctl_pkg::CFG_TWO_OFS);
		check({7'h00, rd_q[7]}, 8'h00, "ready off when disabled");
		$display("test loop done");

		cv = 3'h0;
		new_run(8'hA0);
		repeat (200) @(posedge core_clk);
		wr(adc_ctl_pkg::CFG_ONE_OFS, 8'h00);
		check(8'(n_starts >= 10), 8'h01, "sweep keeps running");
		foreach (chans[j]) check({5'h00, chans[j]}, 8'(j % 8), "sweep wrap");
		$display("test sweep loop done");
		print_verdict();
	end
endmodule
